/* lrt_consts.svh */
`ifndef LRT_CONSTS_SVH
`define LRT_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define LRT_AW 8
`define LRT_OFS_CTRL 8'h00
`define LRT_OFS_RAST 8'h04
`define LRT_OFS_T0 8'h08
`define LRT_OFS_T1 8'h0c
`define LRT_OFS_T2 8'h10
`define LRT_OFS_STAT 8'h14

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define LRT_CTRL_RST 32'h0000_0200
`define LRT_DIV_MSB 15
`define LRT_DIV_LSB 8
`define LRT_DIV_MIN 8'h02
`define LRT_RAST_EN 0
`define LRT_RAST_ACT 1
`define LRT_T0_PPL 9:0
`define LRT_T0_HSW 15:10
`define LRT_T0_HFP 23:16
`define LRT_T0_HBP 31:24
`define LRT_T1_LPP 9:0
`define LRT_T1_VSW 15:10
`define LRT_T1_VFP 23:16
`define LRT_T1_VBP 31:24
`define LRT_T2_ACB 7:0
`define LRT_T2_IVS 20
`define LRT_T2_IHS 21
`define LRT_T2_EDGE_FALL 24
`define LRT_T2_EDGE_CTL 25
`define LRT_ST_RUN 0
`define LRT_ST_FS 1
`define LRT_ST_LINK 2
`define LRT_RESP_OK 2'b00
`define LRT_RESP_ERR 2'b10
`define LRT_DW 16

`endif

/* lrt_panel_model.sv */
`timescale 1ns/1ps

module lrt_panel_model (
    // panel pins
    input wire logic pixel_clock_out,
    input wire logic line_sync_out,
    input wire logic frame_sync_out,
    input wire logic bias_or_output_enable,
    // panel setup
    input wire logic mode_active,
    // what the panel saw
    output int line_px,
    output int frame_lines
);
    int px_cnt = 0;
    int ln_cnt = 0;

    // ------------------------------------------------------------
    // latching
    // ------------------------------------------------------------
    // active panels latch only while enabled
    always @(posedge pixel_clock_out)
        if (!mode_active || bias_or_output_enable === 1'b1)
            px_cnt++;

    // blank lines keep the last count
    always @(posedge line_sync_out) begin
        if (px_cnt != 0)
            line_px = px_cnt;
        px_cnt = 0;
        ln_cnt++;
    end

    always @(posedge frame_sync_out) begin
        frame_lines = ln_cnt;
        ln_cnt = 0;
    end

endmodule : lrt_panel_model

/* lrt_pkg.sv */
package lrt_pkg;

    typedef enum logic [1:0] {H_BP, H_ACT, H_FP, H_SYNC} lrt_hst_t;
    typedef enum logic [1:0] {V_BP, V_ACT, V_FP, V_SYNC} lrt_vst_t;

    // bus-side state, ref_clk domain
    typedef struct packed {
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bwait;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] rast;
        logic [31:0] t0;
        logic [31:0] t1;
        logic [31:0] t2;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic fs_s1;
        logic fs_s2;
        logic ln_s1;
        logic ln_s2;
        logic run;
    } lrt_ref_t;

    // panel-side state, display_reference_clock domain
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack;
        logic [31:0] c_ctrl;
        logic [31:0] c_rast;
        logic [31:0] c_t0;
        logic [31:0] c_t1;
        logic [31:0] c_t2;
        logic [7:0] cnt;
        lrt_hst_t hst;
        logic [9:0] hcnt;
        lrt_vst_t vst;
        logic [9:0] vcnt;
        logic [7:0] bcnt;
        logic pclk;
        logic hs;
        logic fs;
        logic bias;
        logic [15:0] data;
    } lrt_link_t;

endpackage : lrt_pkg

/* lrt_raster_props.sv */
`timescale 1ns/1ps
`include "lrt_consts.svh"

module lrt_raster_props (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic display_reference_clock,
    // register writes, watched for the mode bit
    input wire logic [`LRT_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // panel ownership
    input wire logic async_panel_active,
    input wire logic raster_active,
    // pixel stream and panel pins
    input wire logic [`LRT_DW-1:0] pix_data,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic pixel_clock_out,
    input wire logic bias_or_output_enable,
    input wire logic [`LRT_DW-1:0] panel_data_bus
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // mode bit only changes while the bench idles, so no synchroniser
    logic act_r;
    logic [1:0] on_r;
    logic [3:0] off_cnt_r;
    logic [8:0] still_r;
    logic pclk_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            act_r <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 s_axi_awaddr == `LRT_OFS_RAST)
            act_r <= s_axi_wdata[`LRT_RAST_ACT];
    end

    always_ff @(posedge display_reference_clock or posedge rst) begin
        if (rst) begin
            on_r <= 2'h0;
            off_cnt_r <= 4'h0;
            still_r <= 9'h0;
            pclk_r <= 1'b0;
        end else begin
            on_r <= {on_r[0], raster_active};
            pclk_r <= pixel_clock_out;
            if (on_r[1])
                off_cnt_r <= 4'h0;
            else if (off_cnt_r != 4'hf)
                off_cnt_r <= off_cnt_r + 4'h1;
            if (!on_r[1] || pixel_clock_out != pclk_r)
                still_r <= 9'h0;
            else if (still_r != 9'h1ff)
                still_r <= still_r + 9'h1;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_take;
        pix_ready && pix_valid;
    endsequence
    sequence s_miss;
        pix_ready && !pix_valid;
    endsequence

    property p_owner;
        @(posedge ref_clk) disable iff (rst) async_panel_active |=> !raster_active;
    endproperty
    property p_idle;
        @(posedge display_reference_clock) disable iff (rst)
            off_cnt_r == 4'hf |-> !pix_ready && !pixel_clock_out;
    endproperty
    property p_take;
        @(posedge display_reference_clock) disable iff (rst)
            s_take |=> panel_data_bus == $past(pix_data);
    endproperty
    property p_black;
        @(posedge display_reference_clock) disable iff (rst)
            s_miss |=> panel_data_bus == 16'h0;
    endproperty
    property p_gap;
        @(posedge display_reference_clock) disable iff (rst) pix_ready |=> !pix_ready;
    endproperty
    property p_low;
        @(posedge display_reference_clock) disable iff (rst) pix_ready |=> !pixel_clock_out;
    endproperty
    property p_oe;
        @(posedge display_reference_clock) disable iff (rst)
            act_r && pix_ready |=> bias_or_output_enable;
    endproperty
    property p_run;
        @(posedge display_reference_clock) disable iff (rst) act_r |-> still_r < 9'h12c;
    endproperty

    a_owner: assert property (p_owner)
        else $error("raster path active while async panel owns the pins");
    a_idle: assert property (p_idle)
        else $error("panel outputs moving while raster path is off");
    a_take: assert property (p_take)
        else $error("panel data differs from the taken pixel");
    a_black: assert property (p_black)
        else $error("underrun slot not sent as zero");
    a_gap: assert property (p_gap)
        else $error("pixel slots closer than the minimum divisor");
    a_low: assert property (p_low)
        else $error("pixel clock not low at slot start");
    a_oe: assert property (p_oe)
        else $error("output enable low while pixel data is on the bus");
    a_run: assert property (p_run)
        else $error("pixel clock stalled in active mode");

endmodule : lrt_raster_props

bind lrt_raster_timing lrt_raster_props lrt_raster_props_i (.*);

/* lrt_raster_timing.sv */
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "lrt_consts.svh"

// How it works
// - the raster path runs only while the async panel controller is idle, and stops one ref_clk cycle after that controller goes active.
// - pixel clock is the reference clock over the divisor, and divisors below two are forced to two.
// - in passive mode the pixel clock moves only during active pixel slots, still in sync and wait states.
// - in active mode the pixel clock runs without pause while the raster path is enabled.
// - line sync follows each line's pixels, with programmable wait states before and after the line.
// - bits 25 and 24 of timing word two pick the pixel clock edge on which both syncs change.
// - line sync has a programmable polarity and a width in pixel clocks.
// - frame sync follows each frame's lines, with programmable line counts at frame start and end.
// - frame sync has a programmable polarity and, in active mode, a programmable width in lines.
// - in passive mode frame sync is asserted during the first line of the screen.
// - in passive mode the bias pin toggles once every programmed count plus one lines.
// - in active mode the bias pin is an output enable, high while pixel data is on the bus.
// - pixel words come from the frame-buffer fetch stream and are sent out continuously.
module lrt_raster_timing
    import lrt_pkg::*;
(
    // system clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [`LRT_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`LRT_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // panel ownership
    input wire logic async_panel_active,
    output logic raster_active,
    // link clock
    input wire logic display_reference_clock,
    // pixel stream from frame-buffer fetch
    input wire logic [`LRT_DW-1:0] pix_data,
    input wire logic pix_valid,
    output logic pix_ready,
    // panel pins
    output logic pixel_clock_out,
    output logic line_sync_out,
    output logic frame_sync_out,
    output logic bias_or_output_enable,
    output logic [`LRT_DW-1:0] panel_data_bus
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    function automatic logic [31:0] lrt_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lrt_merge

    lrt_ref_t s_r;
    lrt_ref_t s_nxt;
    lrt_link_t l_r;
    lrt_link_t l_nxt;

    // ------------------------------------------------------------
    // register bus, ref_clk domain
    // ------------------------------------------------------------

    always_comb begin
        s_nxt = s_r;
        s_axi_awready = !s_r.aw_got && !s_r.bwait && !s_r.bvalid;
        s_axi_wready = !s_r.w_got && !s_r.bwait && !s_r.bvalid;
        s_axi_arready = !s_r.rvalid;

        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end

        // registers stay frozen until the link side has copied them
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bresp = `LRT_RESP_OK;
            case (s_r.awaddr)
                `LRT_OFS_CTRL: s_nxt.ctrl = lrt_merge(s_r.ctrl, s_r.wdata, s_r.wstrb);
                `LRT_OFS_RAST: s_nxt.rast = lrt_merge(s_r.rast, s_r.wdata, s_r.wstrb);
                `LRT_OFS_T0: s_nxt.t0 = lrt_merge(s_r.t0, s_r.wdata, s_r.wstrb);
                `LRT_OFS_T1: s_nxt.t1 = lrt_merge(s_r.t1, s_r.wdata, s_r.wstrb);
                `LRT_OFS_T2: s_nxt.t2 = lrt_merge(s_r.t2, s_r.wdata, s_r.wstrb);
                `LRT_OFS_STAT: s_nxt.bresp = `LRT_RESP_OK;
                default: s_nxt.bresp = `LRT_RESP_ERR;
            endcase
            s_nxt.req = ~s_r.req;
            s_nxt.bwait = 1'b1;
        end
        if (s_r.bwait && (s_r.ack_s2 == s_r.req)) begin
            s_nxt.bwait = 1'b0;
            s_nxt.bvalid = 1'b1;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `LRT_RESP_OK;
            case (s_axi_araddr)
                `LRT_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
                `LRT_OFS_RAST: s_nxt.rdata = s_r.rast;
                `LRT_OFS_T0: s_nxt.rdata = s_r.t0;
                `LRT_OFS_T1: s_nxt.rdata = s_r.t1;
                `LRT_OFS_T2: s_nxt.rdata = s_r.t2;
                `LRT_OFS_STAT: begin
                    s_nxt.rdata = 32'h0000_0000;
                    s_nxt.rdata[`LRT_ST_RUN] = s_r.run;
                    s_nxt.rdata[`LRT_ST_FS] = s_r.fs_s2;
                    s_nxt.rdata[`LRT_ST_LINK] = s_r.ln_s2;
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                    s_nxt.rresp = `LRT_RESP_ERR;
                end
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // status from the link side, level synchronisers
        s_nxt.ack_s1 = l_r.ack;
        s_nxt.ack_s2 = s_r.ack_s1;
        s_nxt.fs_s1 = l_r.fs;
        s_nxt.fs_s2 = s_r.fs_s1;
        s_nxt.ln_s1 = l_r.en_s2;
        s_nxt.ln_s2 = s_r.ln_s1;

        // panel belongs to one controller only
        s_nxt.run = s_r.rast[`LRT_RAST_EN] && !async_panel_active;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= `LRT_CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign raster_active = s_r.run;

    // ------------------------------------------------------------
    // panel timing, display_reference_clock domain
    // ------------------------------------------------------------

    logic [7:0] div_v;
    logic [7:0] half_v;
    logic wrap_v;
    logic rise_v;
    logic act_v;
    logic passive_v;
    logic edge_rise_v;
    logic line_end_v;
    logic [9:0] lim_v;

    always_comb begin
        l_nxt = l_r;
        pix_ready = 1'b0;
        lim_v = 10'h000;
        line_end_v = 1'b0;

        l_nxt.en_s1 = s_r.run;
        l_nxt.en_s2 = l_r.en_s1;
        l_nxt.req_s1 = s_r.req;
        l_nxt.req_s2 = l_r.req_s1;
        l_nxt.req_s3 = l_r.req_s2;

        // config words are held still by the bus side until ack returns
        if (l_r.req_s2 != l_r.req_s3) begin
            l_nxt.c_ctrl = s_r.ctrl;
            l_nxt.c_rast = s_r.rast;
            l_nxt.c_t0 = s_r.t0;
            l_nxt.c_t1 = s_r.t1;
            l_nxt.c_t2 = s_r.t2;
            l_nxt.ack = l_r.req_s2;
        end

        div_v = l_r.c_ctrl[`LRT_DIV_MSB:`LRT_DIV_LSB];
        if (div_v < `LRT_DIV_MIN) begin
            div_v = `LRT_DIV_MIN;
        end
        half_v = div_v >> 1;
        wrap_v = (l_r.cnt >= div_v - 8'h01);
        rise_v = (l_r.cnt == half_v - 8'h01);
        passive_v = !l_r.c_rast[`LRT_RAST_ACT];
        edge_rise_v = l_r.c_t2[`LRT_T2_EDGE_CTL] && !l_r.c_t2[`LRT_T2_EDGE_FALL];

        if (!l_r.en_s2) begin
            // idle panel, restart at frame start
            l_nxt.cnt = 8'h00;
            l_nxt.hst = H_BP;
            l_nxt.hcnt = 10'h000;
            l_nxt.vst = V_BP;
            l_nxt.vcnt = 10'h000;
            l_nxt.bcnt = 8'h00;
            l_nxt.pclk = 1'b0;
            l_nxt.hs = l_r.c_t2[`LRT_T2_IHS];
            l_nxt.fs = l_r.c_t2[`LRT_T2_IVS];
            l_nxt.bias = 1'b0;
            l_nxt.data = 16'h0000;
            act_v = 1'b0;
        end else begin
            l_nxt.cnt = wrap_v ? 8'h00 : l_r.cnt + 8'h01;

            if (wrap_v) begin
                // one pixel slot per divider period
                case (l_r.hst)
                    H_BP: lim_v = {2'b00, l_r.c_t0[`LRT_T0_HBP]};
                    H_ACT: lim_v = l_r.c_t0[`LRT_T0_PPL];
                    H_FP: lim_v = {2'b00, l_r.c_t0[`LRT_T0_HFP]};
                    H_SYNC: lim_v = {4'h0, l_r.c_t0[`LRT_T0_HSW]};
                    default: lim_v = 10'h000;
                endcase
                if (l_r.hcnt >= lim_v) begin
                    l_nxt.hcnt = 10'h000;
                    case (l_r.hst)
                        H_BP: l_nxt.hst = H_ACT;
                        H_ACT: l_nxt.hst = H_FP;
                        H_FP: l_nxt.hst = H_SYNC;
                        H_SYNC: begin
                            l_nxt.hst = H_BP;
                            line_end_v = 1'b1;
                        end
                        default: l_nxt.hst = H_BP;
                    endcase
                end else begin
                    l_nxt.hcnt = l_r.hcnt + 10'h001;
                end
            end

            if (line_end_v) begin
                case (l_r.vst)
                    V_BP: lim_v = {2'b00, l_r.c_t1[`LRT_T1_VBP]};
                    V_ACT: lim_v = l_r.c_t1[`LRT_T1_LPP];
                    V_FP: lim_v = {2'b00, l_r.c_t1[`LRT_T1_VFP]};
                    V_SYNC: lim_v = {4'h0, l_r.c_t1[`LRT_T1_VSW]};
                    default: lim_v = 10'h000;
                endcase
                if (l_r.vcnt >= lim_v) begin
                    l_nxt.vcnt = 10'h000;
                    case (l_r.vst)
                        V_BP: l_nxt.vst = V_ACT;
                        V_ACT: l_nxt.vst = V_FP;
                        V_FP: l_nxt.vst = V_SYNC;
                        V_SYNC: l_nxt.vst = V_BP;
                        default: l_nxt.vst = V_BP;
                    endcase
                end else begin
                    l_nxt.vcnt = l_r.vcnt + 10'h001;
                end
                // periodic polarity reversal for passive panels
                if (l_r.bcnt == l_r.c_t2[`LRT_T2_ACB]) begin
                    l_nxt.bcnt = 8'h00;
                    if (passive_v) begin
                        l_nxt.bias = ~l_r.bias;
                    end
                end else begin
                    l_nxt.bcnt = l_r.bcnt + 8'h01;
                end
            end

            act_v = (l_nxt.hst == H_ACT) && (l_nxt.vst == V_ACT);

            if (wrap_v) begin
                l_nxt.pclk = 1'b0;
                pix_ready = act_v;
                // starved fetch sends black rather than stalling the panel
                l_nxt.data = (act_v && pix_valid) ? pix_data : 16'h0000;
                if (!passive_v) begin
                    l_nxt.bias = act_v;
                end
            end
            if (rise_v) begin
                l_nxt.pclk = !passive_v || act_v;
            end

            if ((edge_rise_v && rise_v) || (!edge_rise_v && wrap_v)) begin
                l_nxt.hs = (l_nxt.hst == H_SYNC) ^ l_r.c_t2[`LRT_T2_IHS];
                if (passive_v) begin
                    l_nxt.fs = ((l_nxt.vst == V_ACT) && (l_nxt.vcnt == 10'h000))
                        ^ l_r.c_t2[`LRT_T2_IVS];
                end else begin
                    l_nxt.fs = (l_nxt.vst == V_SYNC) ^ l_r.c_t2[`LRT_T2_IVS];
                end
            end
        end
    end

    // async assert only; release is quiet since the enable sync holds the counters
    always_ff @(posedge display_reference_clock or posedge rst) begin
        if (rst) begin
            l_r <= '0;
            l_r.c_ctrl <= `LRT_CTRL_RST;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign pixel_clock_out = l_r.pclk;
    assign line_sync_out = l_r.hs;
    assign frame_sync_out = l_r.fs;
    assign bias_or_output_enable = l_r.bias;
    assign panel_data_bus = l_r.data;

endmodule : lrt_raster_timing

/* testbench.sv */
`timescale 1ns/1ps
`include "lrt_consts.svh"

module testbench;
    logic ref_clk = 1'b0;
    logic display_reference_clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic async_panel_active = 1'b0;
    logic [15:0] pix_data = 16'h0;
    logic pix_valid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic raster_active, pix_ready, pixel_clock_out, line_sync_out, frame_sync_out;
    logic bias_or_output_enable;
    logic [15:0] panel_data_bus;
    int error_cnt = 0;
    int checks = 0;
    int line_px, frame_lines;
    int min_gap = 99, gap = 99, hs_run = 0, hs_w = 0, bad_pc = 0, bias_tg = 0;
    logic hs_on = 1'b1, mode_act = 1'b1, pc_d = 1'b0, hs_d = 1'b0, bi_d = 1'b0;
    logic [1:0] hs_pe = 2'h0;
    logic [33:0] exp_q[$];
    logic [31:0] seed = 32'h0001_5fd6;

    always #20 ref_clk = ~ref_clk;
    always #7.5 display_reference_clock = ~display_reference_clock;

    lrt_raster_timing lrt_raster_timing_i (.*);

    lrt_panel_model lrt_panel_model_i (
        .pixel_clock_out, .line_sync_out, .frame_sync_out, .bias_or_output_enable,
        .mode_active(mode_act), .line_px, .frame_lines
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // readies come from flops, steady from the falling edge on
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw;
        exp_q.push_back({`LRT_RESP_OK, 32'h0});
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(negedge ref_clk);
        while (s_axi_awvalid || s_axi_wvalid) begin
            ga = s_axi_awready;
            gw = s_axi_wready;
            @(posedge ref_clk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
            @(negedge ref_clk);
        end
        while (s_axi_bvalid !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        exp_q.push_back(exp);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
        @(posedge ref_clk);
        s_axi_rready <= 1'b0;
    endtask : rd

    // settle after a change, then measure afresh
    task automatic phase(input logic lvl, input logic act);
        repeat (200) @(posedge display_reference_clock);
        @(negedge display_reference_clock);
        hs_on = lvl;
        mode_act = act;
        min_gap = 99;
        bad_pc = 0;
        bias_tg = 0;
        repeat (800) @(posedge display_reference_clock);
    endtask : phase

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            check("rd", {s_axi_rresp, s_axi_rdata}, exp_q.size() ? exp_q.pop_front() : 'x);
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            check("wr", {s_axi_bresp, 32'h0}, exp_q.size() ? exp_q.pop_front() : 'x);
    end

    always @(posedge display_reference_clock) begin
        seed = xs(seed);
        pix_data <= seed[15:0];
        pix_valid <= seed[16] | seed[17];
        if (pix_ready === 1'b1) begin
            min_gap = (gap < min_gap) ? gap : min_gap;
            gap = 1;
        end else
            gap++;
        if (line_sync_out === hs_on)
            hs_run++;
        else if (hs_run != 0) begin
            hs_w = hs_run;
            hs_run = 0;
        end
        if (line_sync_out !== hs_d)
            hs_pe = {pc_d, pixel_clock_out};
        if (line_sync_out === hs_on && hs_d === hs_on && pixel_clock_out !== pc_d)
            bad_pc++;
        if (bias_or_output_enable !== bi_d)
            bias_tg++;
        pc_d = pixel_clock_out;
        hs_d = line_sync_out;
        bi_d = bias_or_output_enable;
    end

    // a hang counts as a mismatch
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`LRT_OFS_CTRL, {`LRT_RESP_OK, `LRT_CTRL_RST});
        rd(8'h18, {`LRT_RESP_ERR, 32'h0});
        wr(`LRT_OFS_CTRL, 32'h0000_0300);
        wr(`LRT_OFS_T0, 32'h0101_0403);
        wr(`LRT_OFS_T1, 32'h0000_0001);
        wr(`LRT_OFS_T2, 32'h0);
        rd(`LRT_OFS_T0, {`LRT_RESP_OK, 32'h0101_0403});
        wr(`LRT_OFS_RAST, 32'h3);
        phase(1'b1, 1'b1);
        check("line pixels", line_px, 4);
        check("frame lines", frame_lines, 5);
        check("slot gap", min_gap, 3);
        check("line sync width", hs_w, 6);
        check("line sync edge", hs_pe, 2'h2);
        check("raster active", raster_active, 1'b1);
        wr(`LRT_OFS_T2, 32'h0220_0000);
        wr(`LRT_OFS_CTRL, 32'h0000_0200);
        phase(1'b0, 1'b1);
        check("slot gap", min_gap, 2);
        check("line sync width", hs_w, 4);
        check("line sync edge", hs_pe, 2'h1);
        wr(`LRT_OFS_T2, 32'h0);
        wr(`LRT_OFS_T0, 32'h0101_0405);
        wr(`LRT_OFS_T1, 32'h0000_0002);
        wr(`LRT_OFS_RAST, 32'h1);
        phase(1'b1, 1'b0);
        check("line pixels", line_px, 6);
        check("frame lines", frame_lines, 6);
        check("clock in sync", bad_pc, 0);
        check("bias toggles", bias_tg != 0, 1'b1);
        @(posedge ref_clk);
        async_panel_active <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("raster active", raster_active, 1'b0);
        repeat (40) @(posedge display_reference_clock);
        check("pixel clock", pixel_clock_out, 1'b0);
        @(posedge ref_clk);
        async_panel_active <= 1'b0;
        wr(`LRT_OFS_RAST, 32'h0);
        repeat (40) @(posedge display_reference_clock);
        check("idle pins", {pixel_clock_out, line_sync_out, frame_sync_out,
              bias_or_output_enable}, 4'h0);
        summarize();
    end

endmodule : testbench
